//--- include/dcs_pkg.sv
package dcs_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_CNT_W = 5;
  localparam int unsigned HS_NUM = 16;
  localparam int unsigned HS_IDX_W = 4;

  // fifo thresholds for the half-depth mode
  localparam logic [FIFO_CNT_W-1:0] FIFO_FULL_CNT = 5'h10;
  localparam logic [FIFO_CNT_W-1:0] FIFO_HALF_CNT = 5'h08;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CFG_HIGH = 12'h044;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h048;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h04C;
  localparam logic [ADDR_W-1:0] OFF_SRC_PTR = 12'h058;

  // reset values and writable masks
  localparam logic [DATA_W-1:0] CFG_HIGH_RST = 32'h0000_0004;
  localparam logic [DATA_W-1:0] CFG_HIGH_MASK = 32'h0000_7F9F;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CTRL_MASK = 32'h0000_0FFF;
  localparam logic [DATA_W-1:0] SRC_PTR_RST = 32'h0000_0000;

  // upper configuration word fields
  localparam int unsigned CFG_DST_IF_LSB = 11;
  localparam int unsigned CFG_SRC_IF_LSB = 7;
  localparam int unsigned CFG_PROT_LSB = 2;
  localparam int unsigned CFG_FIFO_MODE_BIT = 1;
  localparam int unsigned CFG_PREFETCH_BIT = 0;

  // channel control word fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_SRC_SW_BIT = 1;
  localparam int unsigned CTRL_DST_SW_BIT = 2;
  localparam int unsigned CTRL_SRC_MEM_BIT = 3;
  localparam int unsigned CTRL_DST_MEM_BIT = 4;
  localparam int unsigned CTRL_INC_LSB = 5;
  localparam int unsigned CTRL_WIDTH_LSB = 7;
  localparam int unsigned CTRL_DST_FC_BIT = 9;
  localparam int unsigned CTRL_SW_SRC_REQ_BIT = 10;
  localparam int unsigned CTRL_SW_DST_REQ_BIT = 11;

  // source address increment codes
  localparam logic [1:0] INC_UP = 2'h0;
  localparam logic [1:0] INC_DOWN = 2'h1;

  typedef enum logic {XF_IDLE, XF_BUSY} dcs_xfer_state_t;

endpackage

//--- include/dcs_fifo_if.sv
`timescale 1ns/100ps
interface dcs_fifo_if #(
  parameter int unsigned W = 32,
  parameter int unsigned CW = 5
);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  logic [CW-1:0] count;

  modport user (output wr_valid, output wr_data, output rd_ready,
                input wr_ready, input rd_valid, input rd_data, input count);
  modport fifo (input wr_valid, input wr_data, input rd_ready,
                output wr_ready, output rd_valid, output rd_data, output count);
endinterface

//--- hw/dcs_fifo.sv
`timescale 1ns/100ps
module dcs_fifo #(
  parameter int unsigned W = 32,
  parameter int unsigned D = 16
) (
  input logic clk,
  input logic rst_n,
  dcs_fifo_if.fifo f
);
  localparam int unsigned AW = $clog2(D);
  localparam int unsigned CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic ovalid_q, ovalid_d;
  logic [W-1:0] odata_q, odata_d;
  logic [CW-1:0] total;
  logic push, pop, load;

  // output stage is a register, so the word count includes it
  always_comb begin
    total = cnt_q + CW'(ovalid_q);
    push = f.wr_valid && (total < DEPTH_C);
    pop = f.rd_ready && ovalid_q;
    load = (cnt_q != '0) && (!ovalid_q || pop);
    wptr_d = push ? wptr_q + AW'(1) : wptr_q;
    rptr_d = load ? rptr_q + AW'(1) : rptr_q;
    cnt_d = cnt_q + CW'(push) - CW'(load);
    ovalid_d = load ? 1'b1 : (pop ? 1'b0 : ovalid_q);
    odata_d = load ? mem[rptr_q] : odata_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      ovalid_q <= 1'b0;
      odata_q <= '0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
      ovalid_q <= ovalid_d;
      odata_q <= odata_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_q] <= f.wr_data;
    end
  end

  assign f.wr_ready = total < DEPTH_C;
  assign f.rd_valid = ovalid_q;
  assign f.rd_data = odata_q;
  assign f.count = total;
endmodule

//--- hw/dcs_channel.sv
// Operation
// - destination hardware handshake picks one of sixteen interfaces by index field
// - source hardware handshake picks one of sixteen interfaces by index field
// - protection field drives the bus protection bits three to one directly
// - bus protection bit zero always high, every access is data
// - upper configuration word resets to four, privileged non-cached data
// - threshold select clear: serve when one single transfer fits or exists
// - threshold select set: destination waits for half-full, except burst end
// - threshold select set: source waits for more than half free, except burst end
// - destination flow control, prefetch control zero: source served at once
// - destination flow control, prefetch control one: source held until destination request and empty fifo, no prefetch
// - source pointer holds current source address, updated after each source transfer
// - source pointer increments, decrements or holds per increment setting
// - handshake kind zero hardware, one software; ignored for memory endpoints
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
module dcs_channel (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [dcs_pkg::ADDR_W-1:0] paddr,
  input logic [dcs_pkg::DATA_W-1:0] pwdata,
  output logic [dcs_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic [dcs_pkg::HS_NUM-1:0] hw_src_req,
  input logic [dcs_pkg::HS_NUM-1:0] hw_dst_req,
  output logic [dcs_pkg::HS_NUM-1:0] hw_src_ack,
  output logic [dcs_pkg::HS_NUM-1:0] hw_dst_ack,
  input logic burst_end,
  output logic src_rd_valid,
  output logic [dcs_pkg::DATA_W-1:0] src_rd_addr,
  input logic src_rd_done,
  input logic [dcs_pkg::DATA_W-1:0] src_rd_data,
  output logic dst_wr_valid,
  output logic [dcs_pkg::DATA_W-1:0] dst_wr_data,
  input logic dst_wr_done,
  output logic [3:0] hprot
);
  import dcs_pkg::*;

  // one request source, chosen by endpoint kind and handshake kind
  function automatic logic pick_req(input logic [HS_NUM-1:0] hw, input logic [HS_IDX_W-1:0] idx,
                                    input logic sw_mode, input logic sw_req,
                                    input logic is_mem);
    logic r;
    r = hw[idx];
    // memory endpoints need no handshake, so they always request
    if (is_mem) begin
      r = 1'b1;
    end else if (sw_mode) begin
      r = sw_req;
    end
    return r;
  endfunction

  function automatic logic [HS_NUM-1:0] ack_vec(input logic [HS_IDX_W-1:0] idx,
                                                input logic hw_mode);
    logic [HS_NUM-1:0] v;
    v = '0;
    // no acknowledge in software mode: the request bit clears itself instead
    if (hw_mode) begin
      v[idx] = 1'b1;
    end
    return v;
  endfunction

  function automatic logic is_reg(input logic [ADDR_W-1:0] a);
    return (a == OFF_CFG_HIGH) || (a == OFF_CTRL) ||
           (a == OFF_STATUS) || (a == OFF_SRC_PTR);
  endfunction

  // the fifo decouples the two sides; its count includes the output stage
  dcs_fifo_if #(.W(DATA_W), .CW(FIFO_CNT_W)) fq ();

  dcs_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .f(fq)
  );

  logic [DATA_W-1:0] cfg_q, cfg_d;
  logic [DATA_W-1:0] ctrl_q, ctrl_d;
  logic [DATA_W-1:0] ptr_q, ptr_d;
  logic [DATA_W-1:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  dcs_xfer_state_t src_st_q, src_st_d;
  dcs_xfer_state_t dst_st_q, dst_st_d;
  logic dst_pend_q, dst_pend_d;
  logic [HS_NUM-1:0] src_ack_q, src_ack_d;
  logic [HS_NUM-1:0] dst_ack_q, dst_ack_d;
  logic [DATA_W-1:0] dst_data_q, dst_data_d;
  logic [3:0] hprot_q, hprot_d;
  logic src_valid_q, src_valid_d;
  logic dst_valid_q, dst_valid_d;

  logic setup, wr_en, hit;
  logic en, src_sw, dst_sw, src_mem, dst_mem, dst_fc, fifo_mode, prefetch_off;
  logic [HS_IDX_W-1:0] src_if, dst_if;
  logic [1:0] inc_mode, width;
  logic [DATA_W-1:0] step;
  logic src_req_act, dst_req_act, src_space_ok, dst_data_ok, src_gate;
  logic src_start, src_fin, dst_start, dst_fin;
  logic [FIFO_CNT_W-1:0] cnt;

  always_comb begin
    en = ctrl_q[CTRL_EN_BIT];
    src_sw = ctrl_q[CTRL_SRC_SW_BIT];
    dst_sw = ctrl_q[CTRL_DST_SW_BIT];
    src_mem = ctrl_q[CTRL_SRC_MEM_BIT];
    dst_mem = ctrl_q[CTRL_DST_MEM_BIT];
    inc_mode = ctrl_q[CTRL_INC_LSB +: 2];
    width = ctrl_q[CTRL_WIDTH_LSB +: 2];
    dst_fc = ctrl_q[CTRL_DST_FC_BIT];
    dst_if = cfg_q[CFG_DST_IF_LSB +: HS_IDX_W];
    src_if = cfg_q[CFG_SRC_IF_LSB +: HS_IDX_W];
    fifo_mode = cfg_q[CFG_FIFO_MODE_BIT];
    prefetch_off = cfg_q[CFG_PREFETCH_BIT];
    cnt = fq.count;
    step = DATA_W'(1) << width;
  end

  // request selection and service conditions
  always_comb begin
    src_req_act = pick_req(hw_src_req, src_if, src_sw,
                           ctrl_q[CTRL_SW_SRC_REQ_BIT], src_mem);
    dst_req_act = pick_req(hw_dst_req, dst_if, dst_sw,
                           ctrl_q[CTRL_SW_DST_REQ_BIT], dst_mem);
    // half-depth mode favours long bursts at the cost of first-word latency
    if (fifo_mode) begin
      src_space_ok = fq.wr_ready &&
                     ((FIFO_FULL_CNT - cnt > FIFO_HALF_CNT) || burst_end);
      dst_data_ok = fq.rd_valid && ((cnt >= FIFO_HALF_CNT) || burst_end);
    end else begin
      src_space_ok = fq.wr_ready;
      dst_data_ok = fq.rd_valid;
    end
    // without prefetch one word is fetched per destination request, so the
    // fifo never holds data the destination might abandon at block end
    if (dst_fc && prefetch_off) begin
      src_gate = dst_pend_q && (cnt == '0);
    end else begin
      src_gate = 1'b1;
    end
    // only one source read is outstanding, so a refused start is simply retried
    src_start = en && (src_st_q == XF_IDLE) && src_req_act && src_space_ok && src_gate;
    src_fin = (src_st_q == XF_BUSY) && src_rd_done;
    dst_start = en && (dst_st_q == XF_IDLE) && dst_req_act && dst_data_ok;
    dst_fin = (dst_st_q == XF_BUSY) && dst_wr_done;
    fq.wr_valid = src_fin;
    fq.wr_data = src_rd_data;
    fq.rd_ready = dst_start;
  end

  // transfer engines
  always_comb begin
    src_st_d = src_st_q;
    dst_st_d = dst_st_q;
    dst_data_d = dst_data_q;
    src_ack_d = '0;
    dst_ack_d = '0;
    unique case (src_st_q)
      XF_IDLE: begin
        if (src_start) begin
          src_st_d = XF_BUSY;
        end
      end
      XF_BUSY: begin
        if (src_rd_done) begin
          src_st_d = XF_IDLE;
          src_ack_d = ack_vec(src_if, !src_sw && !src_mem);
        end
      end
    endcase
    unique case (dst_st_q)
      XF_IDLE: begin
        if (dst_start) begin
          dst_st_d = XF_BUSY;
          dst_data_d = fq.rd_data;
        end
      end
      XF_BUSY: begin
        if (dst_wr_done) begin
          dst_st_d = XF_IDLE;
          dst_ack_d = ack_vec(dst_if, !dst_sw && !dst_mem);
        end
      end
    endcase
    // a destination request seen while enabled is remembered; a new one wins
    dst_pend_d = (dst_pend_q && !dst_start) || (dst_req_act && en);
    // bit zero tied high: the channel never fetches instructions
    hprot_d = {cfg_q[CFG_PROT_LSB +: 3], 1'b1};
    // valid levels come from flops so the far side sees no decode glitches
    src_valid_d = src_st_d == XF_BUSY;
    dst_valid_d = dst_st_d == XF_BUSY;
  end

  // apb slave: zero wait states, answer prepared during the setup cycle
  always_comb begin
    setup = psel && !penable;
    wr_en = psel && penable && pready_q && pwrite && is_reg(paddr);
    hit = is_reg(paddr);
    pready_d = setup;
    // unmapped offsets answer with an error and are never written
    pslverr_d = setup && !hit;
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = '0;
      if (!pwrite) begin
        unique case (paddr)
          OFF_CFG_HIGH: prdata_d = cfg_q & CFG_HIGH_MASK;
          OFF_CTRL: prdata_d = ctrl_q & CTRL_MASK;
          OFF_STATUS: prdata_d = {23'h000000, dst_pend_q, dst_st_q == XF_BUSY,
                                  src_st_q == XF_BUSY, !fq.rd_valid && (cnt == '0),
                                  cnt};
          OFF_SRC_PTR: prdata_d = ptr_q;
          default: prdata_d = '0;
        endcase
      end
    end
  end

  // register file; the software write of a request bit wins over its clear
  always_comb begin
    cfg_d = cfg_q;
    ctrl_d = ctrl_q;
    ptr_d = ptr_q;
    if (src_fin) begin
      unique case (inc_mode)
        INC_UP: ptr_d = ptr_q + step;
        INC_DOWN: ptr_d = ptr_q - step;
        default: ptr_d = ptr_q;
      endcase
    end
    if (src_fin) begin
      ctrl_d[CTRL_SW_SRC_REQ_BIT] = 1'b0;
    end
    if (dst_fin) begin
      ctrl_d[CTRL_SW_DST_REQ_BIT] = 1'b0;
    end
    // a software pointer write in the cycle of a source transfer wins
    if (wr_en) begin
      unique case (paddr)
        OFF_CFG_HIGH: cfg_d = pwdata & CFG_HIGH_MASK;
        OFF_CTRL: ctrl_d = pwdata & CTRL_MASK;
        OFF_SRC_PTR: ptr_d = pwdata;
        default: cfg_d = cfg_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_HIGH_RST;
      ctrl_q <= CTRL_RST;
      ptr_q <= SRC_PTR_RST;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      src_st_q <= XF_IDLE;
      dst_st_q <= XF_IDLE;
      dst_pend_q <= 1'b0;
      src_ack_q <= '0;
      dst_ack_q <= '0;
      dst_data_q <= '0;
      src_valid_q <= 1'b0;
      dst_valid_q <= 1'b0;
      // leaves reset matching the reset protection field
      hprot_q <= {CFG_HIGH_RST[CFG_PROT_LSB +: 3], 1'b1};
    end else begin
      cfg_q <= cfg_d;
      ctrl_q <= ctrl_d;
      ptr_q <= ptr_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      src_st_q <= src_st_d;
      dst_st_q <= dst_st_d;
      dst_pend_q <= dst_pend_d;
      src_ack_q <= src_ack_d;
      dst_ack_q <= dst_ack_d;
      dst_data_q <= dst_data_d;
      hprot_q <= hprot_d;
      src_valid_q <= src_valid_d;
      dst_valid_q <= dst_valid_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign hw_src_ack = src_ack_q;
  assign hw_dst_ack = dst_ack_q;
  assign src_rd_valid = src_valid_q;
  assign src_rd_addr = ptr_q;
  assign dst_wr_valid = dst_valid_q;
  assign dst_wr_data = dst_data_q;
  assign hprot = hprot_q;
endmodule

//--- tb/dcs_channel_sva.sv
`timescale 1ns/100ps
module dcs_channel_chk (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [dcs_pkg::ADDR_W-1:0] paddr,
  input logic [dcs_pkg::DATA_W-1:0] pwdata,
  input logic [dcs_pkg::DATA_W-1:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic [dcs_pkg::HS_NUM-1:0] hw_src_ack,
  input logic [dcs_pkg::HS_NUM-1:0] hw_dst_ack,
  input logic src_rd_valid,
  input logic [dcs_pkg::DATA_W-1:0] src_rd_addr,
  input logic src_rd_done,
  input logic dst_wr_valid,
  input logic dst_wr_done,
  input logic [3:0] hprot
);
  import dcs_pkg::*;
  logic [31:0] cfg_q, ctl_q, step, nxt;
  logic wr;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  // shadow copies, so expectations do not lean on the design's own registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_HIGH_RST;
      ctl_q <= CTRL_RST;
    end else if (wr && paddr == OFF_CFG_HIGH) begin
      cfg_q <= pwdata & CFG_HIGH_MASK;
    end else if (wr && paddr == OFF_CTRL) begin
      ctl_q <= pwdata;
    end
  end
  always_comb begin
    step = 32'h1 << ctl_q[8:7];
    nxt = ctl_q[6:5] == INC_UP ? src_rd_addr + step :
          ctl_q[6:5] == INC_DOWN ? src_rd_addr - step : src_rd_addr;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cfg_wr;
    wr && paddr == OFF_CFG_HIGH;
  endsequence
  sequence s_src_done;
    src_rd_valid && src_rd_done;
  endsequence
  chk_hprot_data: assert property (hprot[0])
    else $error("hprot bit zero low");
  chk_prot_map: assert property (s_cfg_wr |-> ##2 hprot[3:1] == $past(pwdata[4:2], 2))
    else $error("hprot does not follow protection field");
  chk_reset_prot: assert property (!$past(presetn) |-> hprot == 4'h3)
    else $error("hprot wrong after reset");
  chk_ptr_step: assert property (s_src_done ##0 !(wr && paddr == OFF_SRC_PTR)
    |=> src_rd_addr == $past(nxt)) else $error("source pointer step wrong");
  chk_ptr_hold: assert property (src_rd_valid && !src_rd_done
    |=> src_rd_valid && $stable(src_rd_addr)) else $error("source read dropped");
  chk_src_ack: assert property (s_src_done |=> hw_src_ack ==
    (ctl_q[1] || ctl_q[3] ? 16'h0 : 16'h1 << cfg_q[10:7])) else $error("source ack wrong");
  chk_dst_ack: assert property (dst_wr_valid && dst_wr_done |=> hw_dst_ack ==
    (ctl_q[2] || ctl_q[4] ? 16'h0 : 16'h1 << cfg_q[14:11])) else $error("dest ack wrong");
  chk_rsvd_zero: assert property (psel && penable && pready && !pwrite
    && paddr == OFF_CFG_HIGH |-> (prdata & ~CFG_HIGH_MASK) == 32'h0)
    else $error("reserved bits read nonzero");
endmodule
bind dcs_channel dcs_channel_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .hw_src_ack, .hw_dst_ack, .src_rd_valid,
  .src_rd_addr, .src_rd_done, .dst_wr_valid, .dst_wr_done, .hprot);

//--- tb/dcs_far_model.sv
`timescale 1ns/100ps
module dcs_far_model (
  input logic clk,
  input logic rst_n,
  input logic src_rd_valid,
  input logic [dcs_pkg::DATA_W-1:0] src_rd_addr,
  input logic dst_wr_valid,
  input logic [3:0] lat,
  output logic src_rd_done,
  output logic [dcs_pkg::DATA_W-1:0] src_rd_data,
  output logic dst_wr_done
);
  int sc, dc;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {src_rd_done, dst_wr_done, sc, dc} <= '0;
      src_rd_data <= 32'h0;
    end else begin
      src_rd_done <= 1'b0;
      dst_wr_done <= 1'b0;
      // data bus toggles when idle so a stale word is never mistaken for a fresh one
      src_rd_data <= ~src_rd_data;
      if (src_rd_valid && !src_rd_done) begin
        sc <= sc >= lat ? 0 : sc + 1;
        if (sc >= lat) begin
          src_rd_done <= 1'b1;
          src_rd_data <= ~src_rd_addr;
        end
      end
      if (dst_wr_valid && !dst_wr_done) begin
        dc <= dc >= lat ? 0 : dc + 1;
        dst_wr_done <= dc >= lat;
      end
    end
  end
endmodule

//--- tb/dma_channel_cfg_high_and_src_pointer_tb_top.sv
`timescale 1ns/100ps
module dma_channel_cfg_high_and_src_pointer_tb_top;
  import dcs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, burst_end = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, src_rd_addr, src_rd_data, dst_wr_data, rd, base, del;
  logic [15:0] hw_src_req = '0, hw_dst_req = '0, hw_src_ack, hw_dst_ack;
  logic pready, pslverr, src_rd_valid, src_rd_done, dst_wr_valid, dst_wr_done, err;
  logic seen = 0, mon = 0;
  logic [3:0] hprot, lat = '0;
  int bad_count = 0, checks = 0, nack = 0, ndst = 0, first = -1;
  dcs_channel dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .hw_src_req, .hw_dst_req, .hw_src_ack, .hw_dst_ack, .burst_end,
    .src_rd_valid, .src_rd_addr, .src_rd_done, .src_rd_data, .dst_wr_valid, .dst_wr_data,
    .dst_wr_done, .hprot);
  dcs_far_model far (.clk(pclk), .rst_n(presetn), .src_rd_valid, .src_rd_addr,
    .dst_wr_valid, .lat, .src_rd_done, .src_rd_data, .dst_wr_done);
  initial begin
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst;
    @(posedge pclk);
    {presetn, hw_src_req, hw_dst_req, burst_end, mon} <= '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  always @(posedge pclk) begin
    if (src_rd_valid === 1'b1) seen = 1;
    if (presetn && mon) begin
      if (hw_src_ack[5] === 1'b1) nack++;
      if (dst_wr_valid && dst_wr_done) begin
        chk(dst_wr_data, ~(base + del * 32'(ndst)), "dest data");
        if (first < 0) first = nack;
        ndst++;
      end
    end
  end
  task automatic t_regs;
    rst;
    apb(0, OFF_CFG_HIGH, 0);
    chk(rd, CFG_HIGH_RST, "cfg reset");
    chk(hprot, 4'h3, "hprot reset");
    apb(0, OFF_SRC_PTR, 0);
    chk(rd, SRC_PTR_RST, "ptr reset");
    apb(1, OFF_SRC_PTR, 32'hA5A5_5A5C);
    apb(0, OFF_SRC_PTR, 0);
    chk(rd, 32'hA5A5_5A5C, "ptr rw");
    apb(1, OFF_CFG_HIGH, 32'hFFFF_FFFF);
    apb(0, OFF_CFG_HIGH, 0);
    chk(rd, 32'h0000_7F9F, "cfg reserved");
    for (int p = 0; p < 8; p++) begin
      apb(1, OFF_CFG_HIGH, p << 2);
      repeat (2) @(posedge pclk);
      chk(hprot, {p[2:0], 1'b1}, "hprot map");
    end
    apb(0, 12'h0F0, 0);
    chk(err, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped read");
    $display("register test done");
  endtask
  task automatic flow(input logic [1:0] inc, input logic [1:0] w, input logic md, input int l);
    int n;
    rst;
    lat <= 4'(l);
    {nack, ndst, n, first} = {32'h0, 32'h0, 32'h0, -32'sh1};
    base = 32'h0000_1000;
    del = inc == INC_UP ? 32'h1 << w : inc == INC_DOWN ? -(32'h1 << w) : 32'h0;
    mon = 1;
    apb(1, OFF_SRC_PTR, base);
    apb(1, OFF_CFG_HIGH, 32'h0000_4A84 | md << 1);
    apb(1, OFF_CTRL, 32'h1 | inc << 5 | w << 7);
    hw_src_req[5] <= 1'b1;
    hw_dst_req[9] <= 1'b1;
    while (nack < 12 && n++ < 2000) @(posedge pclk);
    chk(nack >= 12, 1'b1, "source stalled");
    hw_src_req <= '0;
    burst_end <= md;
    repeat (100) @(posedge pclk);
    apb(0, OFF_SRC_PTR, 0);
    chk(rd, base + del * 32'(nack), "pointer");
    chk(ndst, nack, "words moved");
    chk(first >= 8, md, "threshold");
    $display("flow test done");
  endtask
  task automatic t_half;
    rst;
    lat <= 4'h0;
    apb(1, OFF_CFG_HIGH, 32'h0000_4A86);
    apb(1, OFF_CTRL, 32'h1);
    hw_src_req[5] <= 1'b1;
    repeat (80) @(posedge pclk);
    apb(0, OFF_STATUS, 0);
    chk(rd[4:0], FIFO_HALF_CNT, "half space stop");
    burst_end <= 1'b1;
    repeat (80) @(posedge pclk);
    apb(0, OFF_STATUS, 0);
    chk(rd[4:0], FIFO_FULL_CNT, "burst end fills");
    $display("half depth test done");
  endtask
  task automatic t_index;
    rst;
    apb(1, OFF_CFG_HIGH, 32'h0000_0284);
    apb(1, OFF_CTRL, 32'h11);
    hw_src_req <= 16'hFFDF;
    seen = 0;
    repeat (30) @(posedge pclk);
    chk(seen, 0, "wrong index");
    apb(1, OFF_CTRL, 32'h13);
    hw_src_req <= 16'hFFFF;
    repeat (30) @(posedge pclk);
    chk(seen, 0, "hw ignored in sw mode");
    apb(1, OFF_CTRL, 32'h413);
    repeat (30) @(posedge pclk);
    chk(seen, 1, "sw request");
    $display("index test done");
  endtask
  task automatic t_prefetch(input logic pf);
    rst;
    apb(1, OFF_CFG_HIGH, 32'h0000_4A84 | pf);
    apb(1, OFF_CTRL, 32'h201);
    hw_src_req[5] <= 1'b1;
    seen = 0;
    repeat (30) @(posedge pclk);
    chk(seen, !pf, "prefetch gate");
    hw_dst_req[9] <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(seen, 1, "served after dest request");
    $display("prefetch test done");
  endtask
  initial begin
    #400000;
    bad_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    give_verdict;
  end
  initial begin
    t_regs;
    flow(INC_UP, 2'h2, 1'b0, 0);
    flow(INC_DOWN, 2'h0, 1'b1, 3);
    flow(2'h2, 2'h1, 1'b0, 1);
    t_half;
    t_index;
    t_prefetch(1'b0);
    t_prefetch(1'b1);
    give_verdict;
  end
endmodule
